// *** src/asc_pkg.sv ***
// asc_pkg: constants, field layouts and carrier types for the converter
// status word and its configuration checker.
// assumes one 20 MHz clock; nothing here holds state.
package asc_pkg;

  // channel count and field geometry
  localparam int CH_COUNT = 6;
  localparam int CH_PER_MAP = 3;
  localparam int MAP_BYTE = 8;

  // primary_control field positions (cal select [7:6], single cycle [1])
  localparam int CAL_LSB = 6;
  localparam int SINGLE_CYCLE_SELECT_BIT = 1;
  // sequencer control: mode field [4:3]
  localparam int SEQ_MODE_LSB = 3;

  // codes checked by the fault logic
  localparam logic [1:0] CAL_RESERVED = 2'h3;
  localparam logic [1:0] SCAN_MODE_A = 2'h2;
  localparam logic [1:0] SCAN_MODE_B = 2'h3;
  localparam logic [2:0] ORD_BAD_LO = 3'h0;
  localparam logic [2:0] ORD_BAD_HI = 3'h7;

  // power state field codes
  localparam logic [1:0] PD_CONVERT = 2'h0;
  localparam logic [1:0] PD_SLEEP = 2'h1;
  localparam logic [1:0] PD_STANDBY = 2'h2;
  localparam logic [1:0] PD_RESET = 2'h3;

  // reset values of status bits
  localparam logic REF_PRESENT_RESET = 1'b1;
  localparam logic [5:0] READY_RESET = 6'h00;

  // timing: reference flag valid no later than 30 us into a conversion
  localparam int CLK_PERIOD_NS = 50;
  localparam int REF_VALID_NS = 30000;
  localparam int REF_VALID_INT = (REF_VALID_NS / CLK_PERIOD_NS) < 1 ? 1 : (REF_VALID_NS / CLK_PERIOD_NS);
  localparam logic [9:0] REF_VALID_CYCLES = 10'(REF_VALID_INT);
  // last count of the internal reset phase after reset_i is released; standby follows one cycle later
  localparam logic [2:0] RESET_HOLD_LAST = 3'h3;

  // one channel's byte in a channel map register
  typedef struct packed {
    logic [2:0] gpo_sel;
    logic [2:0] order;
    logic scan_en;
    logic drive_en;
  } asc_chan_cfg_type;

  // registered configuration faults
  typedef struct packed {
    logic scan;
    logic order;
    logic map;
    logic config_err;
  } asc_fault_type;

  // 24-bit status word, msb first
  typedef struct packed {
    logic reserved;
    logic in_reset;
    logic [5:0] result_ready;
    logic scan_fault;
    logic ref_present;
    logic order_fault;
    logic map_fault;
    logic config_error;
    logic [2:0] overrange;
    logic [3:0] rate;
    logic [1:0] power_state;
    logic mod_active;
    logic data_ready;
  } asc_status_type;

  typedef enum logic [1:0] {ST_RESET, ST_STANDBY, ST_SLEEP, ST_CONVERT} asc_state_type;

endpackage

// *** src/asc_status_check.sv ***
// asc_status_check: converter status word and the configuration checker
// that drops conversion to standby on order, map or configuration faults and refuses starts on any fault.
// assumes the serial interface reads converter_status_o and feeds the control
// and channel map registers; ref_low_pin_i is asynchronous to ref_clk_i.
//
// Overview of operation
// [RL1] in-reset flag is 1 while the device sits in its reset state.
// [RL2] in scan modes 2 and 3 a channel's new result sets its ready bit.
// [RL3] a ready bit clears only after a complete read of that channel's result.
// [RL4] all six ready bits clear when a scan starts.
// [RL5] scan modes with no enabled channel or order 000/111 raise scan fault.
// [RL6] conversion commands are aborted while the scan fault stands.
// [RL7] reference flag shows 1 with a proper reference, 0 below 0.35 V.
// [RL8] reference flag reads 0 in sleep and standby.
// [RL9] reference flag valid within 30 us of a start; informational only.
// [RL10] two enabled channels sharing one scan order raise order fault.
// [RL11] an enabled channel with order 000 or 111 raises order fault.
// [RL12] enabled orders must run 001 upward without gaps, else order fault.
// [RL13] while order fault stands the device stays in standby.
// [RL14] two driving channels on one output raise map fault and hold standby.
// [RL15] calibration select 11 raises the configuration error.
// [RL16] single cycle select 0 in scan mode 2 or 3 raises the configuration error.
// [RL17] a configuration error puts the device in standby.
// [RL18] power state field: 00 convert, 01 sleep, 10 standby, 11 reset.
// [RL19] modulator active flag is 1 during conversion or calibration.
// [RL20] the status word is read only; only internal logic changes it.
`timescale 1ns/1ps
`default_nettype none

module asc_status_check (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic reset_i,
  // configuration registers
  input wire logic [7:0] primary_control_i,
  input wire logic [7:0] seq_control_i,
  input wire logic [23:0] channel_map_upper_i,
  input wire logic [23:0] channel_map_lower_i,
  // commands and modulator events
  input wire logic cmd_convert_i,
  input wire logic cmd_sleep_i,
  input wire logic cmd_standby_i,
  input wire logic conv_done_i,
  input wire logic cal_busy_i,
  // per-channel result events
  input wire logic [5:0] result_avail_i,
  input wire logic [5:0] result_read_done_i,
  // reference comparator pin, high when the reference is missing
  input wire logic ref_low_pin_i,
  // status
  output asc_pkg::asc_status_type converter_status_o,
  output logic cmd_aborted_o
);

  // pick one channel's byte out of the two map registers
  function automatic asc_pkg::asc_chan_cfg_type chan_cfg(input logic [23:0] upper, input logic [23:0] lower,
                                                         input int idx);
    logic [23:0] word;
    int lane;
    word = (idx >= asc_pkg::CH_PER_MAP) ? upper : lower;
    lane = (idx >= asc_pkg::CH_PER_MAP) ? idx - asc_pkg::CH_PER_MAP : idx;
    return asc_pkg::asc_chan_cfg_type'(word[lane*asc_pkg::MAP_BYTE +: asc_pkg::MAP_BYTE]);
  endfunction

  // order codes never allowed on an enabled channel
  function automatic logic order_invalid(input logic [2:0] ord);
    return (ord == asc_pkg::ORD_BAD_LO) || (ord == asc_pkg::ORD_BAD_HI);
  endfunction

  asc_pkg::asc_chan_cfg_type cfg [asc_pkg::CH_COUNT];
  asc_pkg::asc_fault_type fault_ff;
  asc_pkg::asc_fault_type nxt_fault;
  asc_pkg::asc_state_type state_ff;
  asc_pkg::asc_state_type nxt_state;
  logic [1:0] scan_mode_sel;
  logic scan_mode_w;
  logic [1:0] cal_sel;
  logic single_cycle_select_w;
  logic [5:0] en_vec;
  logic [2:0] en_count;
  logic [2:0] max_ord;
  logic any_bad;
  logic dup_ord;
  logic dup_gpo;
  logic block_w;
  logic start_ok;
  logic scan_start_w;
  logic [2:0] reset_cnt_ff;
  logic [5:0] channel_result_ready_ff;
  logic in_reset_ff;
  logic [1:0] pdstat_ff;
  logic [1:0] nxt_pdstat;
  logic mod_active_ff;
  logic cmd_aborted_ff;
  logic ref_meta_ff;
  logic ref_s2_ff;
  logic ref_s3_ff;
  logic ref_low_ff;
  logic [9:0] ref_cnt_ff;
  logic ref_present_ff;

  // control fields
  assign scan_mode_sel = seq_control_i[asc_pkg::SEQ_MODE_LSB +: 2];
  assign scan_mode_w = (scan_mode_sel == asc_pkg::SCAN_MODE_A) || (scan_mode_sel == asc_pkg::SCAN_MODE_B);
  assign cal_sel = primary_control_i[asc_pkg::CAL_LSB +: 2];
  assign single_cycle_select_w = primary_control_i[asc_pkg::SINGLE_CYCLE_SELECT_BIT];

  // per-channel decode of the map registers
  for (genvar g = 0; g < asc_pkg::CH_COUNT; g++) begin : g_cfg
    assign cfg[g] = chan_cfg(channel_map_upper_i, channel_map_lower_i, g);
    assign en_vec[g] = cfg[g].scan_en;
  end

  // configuration checks; pairwise compare is cheap at six channels
  always_comb begin
    en_count = 3'h0;
    max_ord = 3'h0;
    any_bad = 1'b0;
    dup_ord = 1'b0;
    dup_gpo = 1'b0;
    for (int i = 0; i < asc_pkg::CH_COUNT; i++) begin
      if (cfg[i].scan_en) begin
        en_count = en_count + 3'h1;
        if (order_invalid(cfg[i].order)) begin
          any_bad = 1'b1; // RL11
        end
        if (cfg[i].order > max_ord) begin
          max_ord = cfg[i].order;
        end
      end
      for (int j = i + 1; j < asc_pkg::CH_COUNT; j++) begin
        if (cfg[i].scan_en && cfg[j].scan_en && (cfg[i].order == cfg[j].order)) begin
          dup_ord = 1'b1; // RL10
        end
        if (cfg[i].drive_en && cfg[j].drive_en && (cfg[i].gpo_sel == cfg[j].gpo_sel)) begin
          dup_gpo = 1'b1; // RL14
        end
      end
    end
  end

  // distinct orders within 1..6 whose maximum equals the count are exactly 1..n
  always_comb begin
    nxt_fault.scan = scan_mode_w && ((en_count == 3'h0) || any_bad); // RL5
    nxt_fault.order = dup_ord || any_bad || (max_ord != en_count); // RL10 RL11 RL12
    nxt_fault.map = dup_gpo; // RL14
    nxt_fault.config_err = (cal_sel == asc_pkg::CAL_RESERVED) || (scan_mode_w && !single_cycle_select_w); // RL15 RL16
  end

  // faults follow the settings; they drop once the setting is corrected
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      fault_ff <= '0;
    end else begin
      fault_ff <= nxt_fault;
    end
  end

  // any of these drops conversion to standby and refuses starts; scan fault only refuses new starts
  assign block_w = fault_ff.order || fault_ff.map || fault_ff.config_err; // RL13 RL14 RL17
  assign start_ok = cmd_convert_i && !block_w && !fault_ff.scan; // RL6

  // power state sequencing
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      asc_pkg::ST_RESET: begin
        if (reset_cnt_ff == asc_pkg::RESET_HOLD_LAST) begin
          nxt_state = asc_pkg::ST_STANDBY;
        end
      end
      asc_pkg::ST_STANDBY: begin
        if (start_ok) begin
          nxt_state = asc_pkg::ST_CONVERT;
        end else if (cmd_sleep_i) begin
          nxt_state = asc_pkg::ST_SLEEP;
        end
      end
      asc_pkg::ST_SLEEP: begin
        if (start_ok) begin
          nxt_state = asc_pkg::ST_CONVERT;
        end else if (cmd_standby_i) begin
          nxt_state = asc_pkg::ST_STANDBY;
        end
      end
      asc_pkg::ST_CONVERT: begin
        if (block_w) begin
          nxt_state = asc_pkg::ST_STANDBY; // RL13 RL14 RL17
        end else if (cmd_sleep_i) begin
          nxt_state = asc_pkg::ST_SLEEP;
        end else if (cmd_standby_i || conv_done_i) begin
          nxt_state = asc_pkg::ST_STANDBY;
        end
      end
      default: begin
        nxt_state = asc_pkg::ST_RESET;
      end
    endcase
  end

  // state register and reset phase counter
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      state_ff <= asc_pkg::ST_RESET;
      reset_cnt_ff <= 3'h0;
    end else begin
      state_ff <= nxt_state;
      reset_cnt_ff <= (state_ff == asc_pkg::ST_RESET) ? reset_cnt_ff + 3'h1 : 3'h0;
    end
  end

  // power state code, registered alongside the state
  always_comb begin
    case (nxt_state)
      asc_pkg::ST_CONVERT: nxt_pdstat = asc_pkg::PD_CONVERT;
      asc_pkg::ST_SLEEP: nxt_pdstat = asc_pkg::PD_SLEEP;
      asc_pkg::ST_STANDBY: nxt_pdstat = asc_pkg::PD_STANDBY;
      default: nxt_pdstat = asc_pkg::PD_RESET;
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      pdstat_ff <= asc_pkg::PD_RESET;
      in_reset_ff <= 1'b1;
    end else begin
      pdstat_ff <= nxt_pdstat; // RL18
      in_reset_ff <= (nxt_state == asc_pkg::ST_RESET); // RL1
    end
  end

  // modulator busy covers conversion and both calibrations
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      mod_active_ff <= 1'b0;
    end else begin
      mod_active_ff <= (nxt_state == asc_pkg::ST_CONVERT) || cal_busy_i; // RL19
    end
  end

  // refused commands pulse once so software can see why nothing started
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      cmd_aborted_ff <= 1'b0;
    end else begin
      cmd_aborted_ff <= cmd_convert_i && (fault_ff.scan || block_w); // RL6
    end
  end

  // a scan starts on the edge into conversion with a scan mode selected
  assign scan_start_w = scan_mode_w && (state_ff != asc_pkg::ST_CONVERT) && (nxt_state == asc_pkg::ST_CONVERT);

  // ready bits: scan start clears all; a result beats a same-cycle read
  for (genvar g = 0; g < asc_pkg::CH_COUNT; g++) begin : g_channel_result_ready
    always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
        channel_result_ready_ff[g] <= asc_pkg::READY_RESET[g];
      end else if (scan_start_w) begin
        channel_result_ready_ff[g] <= 1'b0; // RL4
      end else if (result_avail_i[g] && scan_mode_w) begin
        channel_result_ready_ff[g] <= 1'b1; // RL2
      end else if (result_read_done_i[g]) begin
        channel_result_ready_ff[g] <= 1'b0; // RL3
      end
    end
  end

  // comparator pin synchroniser; a level counts once stages two and three agree
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      ref_meta_ff <= 1'b0;
      ref_s2_ff <= 1'b0;
      ref_s3_ff <= 1'b0;
      ref_low_ff <= 1'b0;
    end else begin
      ref_meta_ff <= ref_low_pin_i;
      ref_s2_ff <= ref_meta_ff;
      ref_s3_ff <= ref_s2_ff;
      if (ref_s2_ff == ref_s3_ff) begin
        ref_low_ff <= ref_s3_ff;
      end
    end
  end

  // settle timer: comparator output is meaningless until the front end runs;
  // counting starts on the edge that takes the start, so the flag lands at 30 us
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      ref_cnt_ff <= 10'h000;
    end else if (nxt_state != asc_pkg::ST_CONVERT) begin
      ref_cnt_ff <= 10'h000;
    end else if (ref_cnt_ff != asc_pkg::REF_VALID_CYCLES) begin
      ref_cnt_ff <= ref_cnt_ff + 10'h001;
    end
  end

  // reference flag; status only, nothing here stops on a missing reference
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      ref_present_ff <= asc_pkg::REF_PRESENT_RESET;
    end else if ((nxt_state == asc_pkg::ST_SLEEP) || (nxt_state == asc_pkg::ST_STANDBY)) begin
      ref_present_ff <= 1'b0; // RL8
    end else if ((state_ff == asc_pkg::ST_CONVERT) && (ref_cnt_ff == asc_pkg::REF_VALID_CYCLES)) begin
      ref_present_ff <= !ref_low_ff; // RL7 RL9
    end
  end

  // status word straight from flops; no write path exists
  always_comb begin
    converter_status_o = '0; // RL20
    converter_status_o.in_reset = in_reset_ff;
    converter_status_o.result_ready = channel_result_ready_ff;
    converter_status_o.scan_fault = fault_ff.scan;
    converter_status_o.ref_present = ref_present_ff;
    converter_status_o.order_fault = fault_ff.order;
    converter_status_o.map_fault = fault_ff.map;
    converter_status_o.config_error = fault_ff.config_err;
    converter_status_o.power_state = pdstat_ff;
    converter_status_o.mod_active = mod_active_ff;
  end

  assign cmd_aborted_o = cmd_aborted_ff;

  // checks
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (reset_i);

  a_in_reset_flag: assert property ( // RL1
    converter_status_o.in_reset == (converter_status_o.power_state == asc_pkg::PD_RESET))
    else $error("in-reset flag disagrees with power state");

  a_channel_result_ready_mode_only: assert property ( // RL2
    (|(channel_result_ready_ff & ~$past(channel_result_ready_ff))) |-> $past(scan_mode_w))
    else $error("ready bit set outside scan mode");

  a_channel_result_ready_read_hold: assert property ( // RL3
    !scan_start_w |=> ((channel_result_ready_ff & $past(channel_result_ready_ff & ~result_read_done_i)) == $past(channel_result_ready_ff & ~result_read_done_i)))
    else $error("ready bit lost without a full read");

  a_channel_result_ready_scan_clear: assert property ( // RL4
    scan_start_w |=> (channel_result_ready_ff == 6'h00))
    else $error("ready bits not cleared at scan start");

  a_scan_fault_set: assert property ( // RL5
    (scan_mode_w && (en_vec == 6'h00)) |=> fault_ff.scan)
    else $error("scan fault missing with empty channel map");

  a_abort_on_fault: assert property ( // RL6
    (cmd_convert_i && fault_ff.scan && (state_ff != asc_pkg::ST_CONVERT))
      |=> (cmd_aborted_o && (state_ff != asc_pkg::ST_CONVERT)))
    else $error("conversion started under scan fault");

  a_ref_quiet: assert property ( // RL8
    ((converter_status_o.power_state == asc_pkg::PD_SLEEP) || (converter_status_o.power_state == asc_pkg::PD_STANDBY))
      |-> !converter_status_o.ref_present)
    else $error("reference flag high in sleep or standby");

  a_ref_settle: assert property ( // RL9
    ((state_ff == asc_pkg::ST_CONVERT) && (nxt_state == asc_pkg::ST_CONVERT)
      && (ref_cnt_ff == asc_pkg::REF_VALID_CYCLES)) |=> (converter_status_o.ref_present == !$past(ref_low_ff)))
    else $error("reference flag not valid after settle time");

  a_order_gap: assert property ( // RL12
    (!dup_ord && !any_bad && (max_ord != en_count)) |=> fault_ff.order)
    else $error("gap in scan order not flagged");

  a_order_standby: assert property ( // RL13
    fault_ff.order |=> (state_ff != asc_pkg::ST_CONVERT) && (converter_status_o.power_state != asc_pkg::PD_CONVERT))
    else $error("converting with order fault");

  a_map_standby: assert property ( // RL14
    (dup_gpo ##1 fault_ff.map) |=> (state_ff != asc_pkg::ST_CONVERT))
    else $error("converting with output map fault");

  a_config_err: assert property ( // RL17
    (cal_sel == asc_pkg::CAL_RESERVED) |=> fault_ff.config_err ##1 (state_ff != asc_pkg::ST_CONVERT))
    else $error("reserved calibration select not forcing standby");

  a_single_cycle_err: assert property ( // RL16
    (scan_mode_w && !single_cycle_select_w) |=> converter_status_o.config_error)
    else $error("continuous scan not flagged");

  a_mod_active: assert property ( // RL19
    (state_ff == asc_pkg::ST_CONVERT) || $past(cal_busy_i) |-> converter_status_o.mod_active)
    else $error("modulator flag low while busy");

endmodule

`default_nettype wire

// *** tb/asc_host_model.sv ***
// asc_host_model: host side of the serial control interface, seen as
// register images and one result-read engine.
// assumes the bench requests writes and reads on ref_clk_i edges.
`timescale 1ns/1ps
`default_nettype none

module asc_host_model (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic reset_i,
  // requests from the bench
  input wire logic wr_i,
  input wire logic [1:0] wr_sel_i,
  input wire logic [23:0] wr_data_i,
  input wire logic rd_start_i,
  input wire logic [2:0] rd_ch_i,
  // register images and read completion
  output logic [7:0] primary_control_o,
  output logic [7:0] seq_control_o,
  output logic [23:0] map_upper_o,
  output logic [23:0] map_lower_o,
  output logic [5:0] rd_done_o
);
  logic rd_busy_ff;
  logic [1:0] rd_cnt_ff;
  logic [2:0] rd_ch_ff;

  // register writes; the reference flag is never read back here, status only
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      primary_control_o <= 8'h00;
      seq_control_o <= 8'h00;
      map_upper_o <= 24'h00_0000;
      map_lower_o <= 24'h00_0000;
    end else if (wr_i) begin
      case (wr_sel_i)
        2'h0: primary_control_o <= wr_data_i[7:0];
        2'h1: seq_control_o <= wr_data_i[7:0];
        2'h2: map_upper_o <= wr_data_i;
        default: map_lower_o <= wr_data_i;
      endcase
    end
  end

  // one byte per cycle; done only after all three bytes, never for a partial read
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      rd_busy_ff <= 1'b0;
      rd_cnt_ff <= 2'h0;
      rd_ch_ff <= 3'h0;
      rd_done_o <= 6'h00;
    end else begin
      rd_done_o <= 6'h00;
      if (!rd_busy_ff && rd_start_i) begin
        rd_busy_ff <= 1'b1;
        rd_cnt_ff <= 2'h0;
        rd_ch_ff <= rd_ch_i;
      end else if (rd_busy_ff) begin
        rd_cnt_ff <= rd_cnt_ff + 2'h1;
        if (rd_cnt_ff == 2'h2) begin
          rd_busy_ff <= 1'b0;
          rd_done_o <= 6'h01 << rd_ch_ff;
        end
      end
    end
  end
endmodule

`default_nettype wire

// *** tb/tb.sv ***
// tb: table-driven bench for the status word and configuration checker.
// assumes asc_status_check and asc_host_model compile before it.
`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin \
  $display("[FAIL] %s expected %h seen %h", nm, ex, got); bad_count++; end end

module tb;
  typedef struct packed {
    logic [7:0] pc;
    logic [7:0] sq;
    logic [23:0] up;
    logic [23:0] lo;
    logic [3:0] flt;
  } asc_row_type;
  logic ref_clk_i, reset_i, wr, rd_start, cal_busy, ref_low;
  logic cmd_convert, cmd_sleep, cmd_standby, conv_done;
  logic [1:0] wr_sel;
  logic [23:0] wr_data;
  logic [2:0] rd_ch;
  logic [5:0] avail, rd_done;
  logic [7:0] pc, sq;
  logic [23:0] up, lo;
  asc_pkg::asc_status_type st;
  logic aborted;
  int bad_count, tests_run;
  asc_row_type rows [14];
  int ab [4] = '{1, 3, 8, 10};

  asc_host_model host (.ref_clk_i(ref_clk_i), .reset_i(reset_i), .wr_i(wr), .wr_sel_i(wr_sel),
    .wr_data_i(wr_data), .rd_start_i(rd_start), .rd_ch_i(rd_ch), .primary_control_o(pc),
    .seq_control_o(sq), .map_upper_o(up), .map_lower_o(lo), .rd_done_o(rd_done));
  asc_status_check uut (.ref_clk_i(ref_clk_i), .reset_i(reset_i), .primary_control_i(pc),
    .seq_control_i(sq), .channel_map_upper_i(up), .channel_map_lower_i(lo), .cmd_convert_i(cmd_convert),
    .cmd_sleep_i(cmd_sleep), .cmd_standby_i(cmd_standby), .conv_done_i(conv_done), .cal_busy_i(cal_busy),
    .result_avail_i(avail), .result_read_done_i(rd_done), .ref_low_pin_i(ref_low),
    .converter_status_o(st), .cmd_aborted_o(aborted));

  // scan-enabled channel byte with a given order; driving channel byte on an output
  function automatic logic [7:0] en(input logic [2:0] o);
    return {3'h0, o, 1'b1, 1'b0};
  endfunction
  function automatic logic [7:0] dr(input logic [2:0] g);
    return {g, 3'h0, 1'b0, 1'b1};
  endfunction

  task automatic summarize();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // four host writes, then time for the image and the fault flops to land
  task automatic cfg(input asc_row_type r);
    @(posedge ref_clk_i) {wr, wr_sel, wr_data} <= {1'b1, 2'h0, 16'h0000, r.pc};
    @(posedge ref_clk_i) {wr_sel, wr_data} <= {2'h1, 16'h0000, r.sq};
    @(posedge ref_clk_i) {wr_sel, wr_data} <= {2'h2, r.up};
    @(posedge ref_clk_i) {wr_sel, wr_data} <= {2'h3, r.lo};
    @(posedge ref_clk_i) wr <= 1'b0;
    repeat (3) @(posedge ref_clk_i);
    #1;
  endtask

  // one-cycle command pulse {convert, sleep, standby, done}; returns where the answer shows
  task automatic cmd(input logic [3:0] c);
    @(posedge ref_clk_i) {cmd_convert, cmd_sleep, cmd_standby, conv_done} <= c;
    @(posedge ref_clk_i) {cmd_convert, cmd_sleep, cmd_standby, conv_done} <= 4'h0;
    #1;
  endtask

  task automatic pulse_avail(input logic [5:0] m);
    @(posedge ref_clk_i) avail <= m;
    @(posedge ref_clk_i) avail <= 6'h00;
    #1;
  endtask

  initial begin
    ref_clk_i = 1'b0;
    forever #25 ref_clk_i = ~ref_clk_i;
  end

  // watchdog sized well past the under one thousand cycles the tests need
  initial begin
    repeat (20000) @(posedge ref_clk_i);
    bad_count++;
    summarize();
  end

  initial begin
    reset_i = 1'b1;
    {wr, rd_start, cal_busy, ref_low, cmd_convert, cmd_sleep, cmd_standby, conv_done} = 8'h00;
    wr_sel = 2'h0;
    wr_data = 24'h00_0000;
    rd_ch = 3'h0;
    avail = 6'h00;
    bad_count = 0;
    tests_run = 0;
    // fault table: {scan, order, map, config}; row 7 is a legal unbroken order run
    rows[0] = '{8'h00, 8'h00, 24'h00_0000, 24'h00_0000, 4'h0};
    rows[1] = '{8'h02, 8'h10, 24'h00_0000, 24'h00_0000, 4'h8};
    rows[2] = '{8'h02, 8'h10, 24'h00_0000, {16'h0000, en(3'h1)}, 4'h0};
    rows[3] = '{8'h00, 8'h00, 24'h00_0000, {16'h0000, en(3'h0)}, 4'h4};
    rows[4] = '{8'h02, 8'h10, 24'h00_0000, {16'h0000, en(3'h7)}, 4'hC};
    rows[5] = '{8'h00, 8'h00, 24'h00_0000, {8'h00, en(3'h1), en(3'h1)}, 4'h4};
    rows[6] = '{8'h00, 8'h00, 24'h00_0000, {8'h00, en(3'h3), en(3'h1)}, 4'h4};
    rows[7] = '{8'h02, 8'h18, {16'h0000, en(3'h4)}, {en(3'h3), en(3'h2), en(3'h1)}, 4'h0};
    rows[8] = '{8'h00, 8'h00, {8'h00, dr(3'h2), 8'h00}, {16'h0000, dr(3'h2)}, 4'h2};
    rows[9] = '{8'h00, 8'h00, 24'h00_0000, {8'h00, dr(3'h3), dr(3'h2)}, 4'h0};
    rows[10] = '{8'hC0, 8'h00, 24'h00_0000, 24'h00_0000, 4'h1};
    rows[11] = '{8'h80, 8'h00, 24'h00_0000, 24'h00_0000, 4'h0};
    rows[12] = '{8'h00, 8'h10, 24'h00_0000, {16'h0000, en(3'h1)}, 4'h1};
    rows[13] = '{8'h00, 8'h18, 24'h00_0000, {16'h0000, en(3'h1)}, 4'h1};

    // reset phase, then standby after the internal hold
    repeat (3) @(posedge ref_clk_i);
    #1;
    `CHK("status in reset", 24'h40_400C, st)
    @(posedge ref_clk_i) reset_i <= 1'b0;
    repeat (8) @(posedge ref_clk_i);
    #1;
    `CHK("status standby", 24'h00_0008, st)
    $display("test reset done");

    // ordinary cases: every row, one flag group compare each
    for (int i = 0; i < 14; i++) begin
      cfg(rows[i]);
      // scan, order, map and config fault bits of the status word
      `CHK("fault flags", rows[i].flt, {st[15], st[13:11]})
    end
    $display("test fault table done");

    // each fault kind refuses a start and keeps standby
    foreach (ab[i]) begin
      cfg(rows[ab[i]]);
      cmd(4'h8);
      `CHK("aborted", 1'b1, aborted)
      `CHK("power held", asc_pkg::PD_STANDBY, st.power_state)
    end
    $display("test abort done");

    // conversion, reference settle, loss of reference, sleep, standby, calibration
    cfg(rows[0]);
    cmd(4'h8);
    `CHK("aborted clean", 1'b0, aborted)
    `CHK("power convert", {asc_pkg::PD_CONVERT, 1'b1}, {st.power_state, st.mod_active})
    // exactly 30 us after the edge that took the start
    repeat (600) @(posedge ref_clk_i);
    #1;
    `CHK("ref present", 1'b1, st.ref_present)
    @(posedge ref_clk_i) ref_low <= 1'b1;
    repeat (12) @(posedge ref_clk_i);
    #1;
    `CHK("ref missing", 1'b0, st.ref_present)
    `CHK("still convert", asc_pkg::PD_CONVERT, st.power_state)
    @(posedge ref_clk_i) ref_low <= 1'b0;
    cmd(4'h4);
    `CHK("sleep", {asc_pkg::PD_SLEEP, 1'b0, 1'b0}, {st.power_state, st.ref_present, st.mod_active})
    cmd(4'h2);
    `CHK("standby", asc_pkg::PD_STANDBY, st.power_state)
    @(posedge ref_clk_i) cal_busy <= 1'b1;
    repeat (2) @(posedge ref_clk_i);
    #1;
    `CHK("cal busy", 1'b1, st.mod_active)
    @(posedge ref_clk_i) cal_busy <= 1'b0;
    cmd(4'h8);
    cfg(rows[10]);
    `CHK("config drops to standby", asc_pkg::PD_STANDBY, st.power_state)
    $display("test conversion done");

    // ready bits: set in scan mode, survive a partial read, clear on full read
    cfg(rows[2]);
    pulse_avail(6'h04);
    `CHK("ready set", 6'h04, st.result_ready)
    @(posedge ref_clk_i) {rd_start, rd_ch} <= {1'b1, 3'h2};
    @(posedge ref_clk_i) rd_start <= 1'b0;
    #1;
    `CHK("ready partial", 6'h04, st.result_ready)
    repeat (6) @(posedge ref_clk_i);
    #1;
    `CHK("ready read", 6'h00, st.result_ready)
    pulse_avail(6'h21);
    `CHK("ready two", 6'h21, st.result_ready)
    cmd(4'h8);
    `CHK("scan start clears", 6'h00, st.result_ready)
    cmd(4'h1);
    cfg(rows[0]);
    pulse_avail(6'h20);
    `CHK("ready ignored", 6'h00, st.result_ready)
    $display("test ready done");

    // reset in mid-run: ready bits and images drop, reset phase holds, early start ignored
    cfg(rows[2]);
    pulse_avail(6'h08);
    @(posedge ref_clk_i) reset_i <= 1'b1;
    repeat (3) @(posedge ref_clk_i);
    #1;
    `CHK("status reset again", 24'h40_400C, st)
    @(posedge ref_clk_i) reset_i <= 1'b0;
    repeat (2) @(posedge ref_clk_i);
    #1;
    `CHK("reset phase held", 24'h40_400C, st)
    cmd(4'h8);
    `CHK("early start ignored", {1'b0, 24'h00_0008}, {aborted, st})
    $display("test mid-run reset done");
    summarize();
  end
endmodule

`default_nettype wire
